// ### rlt_pkg.sv
/*
 * rlt_pkg: shared constants and types for the rail-2 loop tuning register bank.
 * assumes a 50 MHz core clock and a command decoder that already qualifies page 1.
 */
package rlt_pkg;

    // ==========================================================================
    // clock and timing
    // ==========================================================================
    localparam int          RLT_CLK_PERIOD_NS = 20;          // core_clk at 50 MHz
    localparam int          RLT_TW            = 24;          // timer width in ns units
    localparam int          RLT_FINE_NS       = 5;           // 5 ns per count fields
    localparam int          RLT_COARSE_NS     = 10;          // 10 ns per count field
    localparam int          RLT_HOLD_UNIT_NS  = 100000;      // 100 us per count
    localparam logic [RLT_TW-1:0] RLT_STEP_NS = RLT_TW'(RLT_CLK_PERIOD_NS);

    // ==========================================================================
    // register map (page 1 command codes)
    // ==========================================================================
    localparam int NREG = 15;
    localparam int IX_SHED = 0;
    localparam int IX_OSR  = 1;
    localparam int IX_BLNK = 2;
    localparam int IX_SR3  = 3;
    localparam int IX_CL3  = 4;
    localparam int IX_SR2  = 5;
    localparam int IX_CL2  = 6;
    localparam int IX_SR1  = 7;
    localparam int IX_CL1  = 8;
    localparam int IX_SRD  = 9;
    localparam int IX_CLD  = 10;
    localparam int IX_TRM1 = 11;
    localparam int IX_TRM2 = 12;
    localparam int IX_GAIN = 13;
    localparam int IX_HOLD = 14;

    // command codes, in index order
    localparam logic [7:0] RLT_OFS [NREG] = '{
        8'hcc, 8'hcd, 8'hce, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda,
        8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'he2, 8'he3};
    // writable bits; everything else is reserved and reads as zero
    localparam logic [15:0] RLT_MASK [NREG] = '{
        16'h0007, 16'h1fff, 16'h0fff, 16'h03ff, 16'h03ff, 16'h03ff, 16'h03ff, 16'h007f,
        16'h03ff, 16'h003f, 16'h03ff, 16'h7fff, 16'h001f, 16'h07ff, 16'h00ff};
    localparam logic [15:0] RLT_RST = 16'h0000;

    // ==========================================================================
    // field positions
    // ==========================================================================
    localparam int B_EXIT_LOW  = 2;
    localparam int B_EXIT_FREQ = 1;
    localparam int B_EXIT_OC   = 0;
    localparam int F_OSR_OFF_L = 7;
    localparam int F_OSR_OFF_W = 6;
    localparam int F_OSR_GAP_L = 0;
    localparam int F_OSR_GAP_W = 7;
    localparam int F_SRST_L    = 6;
    localparam int F_SRST_W    = 6;
    localparam int F_BLNK_L    = 0;
    localparam int F_BLNK_W    = 6;
    localparam int F_CLAMP_L   = 0;
    localparam int F_CLAMP_W   = 10;
    localparam int F_CAP_L     = 6;
    localparam int F_CAP_W     = 4;
    localparam int F_CAP1_W    = 1;
    localparam int F_CUR_L     = 0;
    localparam int F_CUR_W     = 6;
    localparam int F_TRM2P_L   = 10;
    localparam int F_TRM1P_L   = 5;
    localparam int F_TRMD_L    = 0;
    localparam int F_TRM3P_L   = 0;
    localparam int F_TRM_W     = 5;
    localparam int B_FMT       = 10;
    localparam int F_DCG_L     = 4;
    localparam int F_DCG_W     = 6;
    localparam int F_CBG_L     = 0;
    localparam int F_CBG_W     = 4;
    localparam int B_HOLD_TRN  = 7;
    localparam int B_HOLD_PRD  = 6;
    localparam int B_HOLD_PS   = 5;
    localparam int B_HOLD_DVT  = 4;
    localparam int F_HOLD_T_L  = 0;
    localparam int F_HOLD_T_W  = 4;

    // timers
    localparam int NTMR   = 6;
    localparam int T_OFF  = 0;
    localparam int T_GAP  = 1;
    localparam int T_BLNK = 2;
    localparam int T_SRST = 3;
    localparam int T_CLMP = 4;
    localparam int T_HOLD = 5;

    // ==========================================================================
    // types
    // ==========================================================================
    typedef enum logic [1:0] {
        RLT_PH_DCM = 2'b00,
        RLT_PH_1P  = 2'b01,
        RLT_PH_2P  = 2'b10,
        RLT_PH_3P  = 2'b11
    } rlt_phase_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } rlt_cmd_s;

    // analog window and fault events, asynchronous to core_clk
    typedef struct packed {
        logic fb_high;
        logic fb_low;
        logic freq_limit;
        logic oc_phase1;
    } rlt_evt_s;

    typedef struct packed {
        logic [9:0] clamp_time;
        logic [3:0] slope_cap;
        logic [5:0] slope_cur;
        logic [4:0] trim;
        logic       report_format;
        logic [5:0] dc_gain;
        logic [3:0] cb_gain;
    } rlt_cfg_s;

    typedef struct packed {
        logic [RLT_TW-1:0] rem;
        logic              busy;
    } rlt_tmr_s;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] q;
    } rlt_sync_s;

    typedef struct packed {
        logic [NREG-1:0][15:0] regs;
        logic [15:0]           rd_data;
        logic                  rd_ack;
        logic                  shed_exit;
        logic                  cb_hold;
        rlt_phase_e            phase_prev;
        logic                  dvt_prev;
        rlt_cfg_s              cfg;
    } rlt_main_s;

endpackage

// ### rlt_pin_sync.sv
/*
 * rlt_pin_sync: three-stage synchroniser for the asynchronous event inputs.
 * assumes inputs are levels that stay long enough to be seen on two edges.
 */
`timescale 1ns/1ps
module rlt_pin_sync (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic [3:0]    din,
    output logic [3:0]         dout
);
    import rlt_pkg::*;

    rlt_sync_s s_reg;
    rlt_sync_s s_next;

    // a bit changes only once the second and third stages agree
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = din;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        s_next.q  = (~(s_reg.s2 ^ s_reg.s3) & s_reg.s3) | ((s_reg.s2 ^ s_reg.s3) & s_reg.q);
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.q;
endmodule // rlt_pin_sync

// ### rlt_ns_timer.sv
/*
 * rlt_ns_timer: retriggerable one-shot measured in nanoseconds.
 * assumes dur_ns is stable in the start cycle; busy lasts ceil(dur/20ns) cycles.
 */
`timescale 1ns/1ps
module rlt_ns_timer (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic                      start,
    input  wire logic [rlt_pkg::RLT_TW-1:0] dur_ns,
    output logic                           busy
);
    import rlt_pkg::*;

    rlt_tmr_s t_reg;
    rlt_tmr_s t_next;

    // load on start, else burn one clock period of remaining time
    always_comb begin
        t_next = t_reg;
        if (start) begin
            t_next.rem = dur_ns;
        end else if (t_reg.rem > RLT_STEP_NS) begin
            t_next.rem = t_reg.rem - RLT_STEP_NS;
        end else begin
            t_next.rem = '0;
        end
        t_next.busy = (t_next.rem != '0);
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign busy = t_reg.busy;
endmodule // rlt_ns_timer

// ### rlt_loop_tuning.sv
/*
 * rlt_loop_tuning: rail-2 loop tuning register bank with its timing helpers.
 * assumes a page-1 command decoder on core_clk, analog events on async pins,
 * and phase, pulse, period and transition status from same-clock control logic.
 */
`timescale 1ns/1ps
module rlt_loop_tuning #(
    parameter int HOLD_UNIT_NS = rlt_pkg::RLT_HOLD_UNIT_NS
) (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire rlt_pkg::rlt_cmd_s  cmd,
    output logic [15:0]             rd_data,
    output logic                    rd_ack,
    input  wire rlt_pkg::rlt_evt_s  evt_pins,
    input  wire rlt_pkg::rlt_phase_e phase_mode,
    input  wire logic               shedding_active,
    input  wire logic               osr_trigger,
    input  wire logic               phase_pulse,
    input  wire logic               slope_reset_sel,
    input  wire logic               period_dev_met,
    input  wire logic               dvt_active,
    output logic                    shed_exit,
    output logic                    cb_hold,
    output logic                    osr_pwm_off,
    output logic                    osr_blocked,
    output logic                    pwm_blanking,
    output logic                    slope_resetting,
    output logic                    slope_clamping,
    output rlt_pkg::rlt_cfg_s       cfg
);
    import rlt_pkg::*;

    // ==========================================================================
    // synchronised events and timers
    // ==========================================================================
    rlt_evt_s           ev;
    rlt_main_s          s_reg;
    rlt_main_s          s_next;
    logic [NTMR-1:0]    t_start;
    logic [RLT_TW-1:0]  t_dur [NTMR];
    logic [NTMR-1:0]    t_busy;
    logic               osr_go;
    logic               hold_evt;

    rlt_pin_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (evt_pins),
        .dout     (ev)
    );

    // one one-shot per timed function
    for (genvar g = 0; g < NTMR; g++) begin : g_tmr
        rlt_ns_timer u_tmr (
            .core_clk (core_clk),
            .nrst     (nrst),
            .start    (t_start[g]),
            .dur_ns   (t_dur[g]),
            .busy     (t_busy[g])
        );
    end

    // ==========================================================================
    // timer starts and durations
    // ==========================================================================
    // overshoot action only when the gap since the last one has expired
    assign osr_go = osr_trigger & ~t_busy[T_GAP];
    // hold events that are enabled
    assign hold_evt =
        (s_reg.regs[IX_HOLD][B_HOLD_TRN] & (ev.fb_high | ev.fb_low))
      | (s_reg.regs[IX_HOLD][B_HOLD_PRD] & period_dev_met)
      | (s_reg.regs[IX_HOLD][B_HOLD_PS]  & (phase_mode != s_reg.phase_prev))
      | (s_reg.regs[IX_HOLD][B_HOLD_DVT] & dvt_active & ~s_reg.dvt_prev);

    always_comb begin
        t_start[T_OFF]  = osr_go;
        t_start[T_GAP]  = osr_go;
        t_start[T_BLNK] = phase_pulse;
        t_start[T_SRST] = phase_pulse & ~slope_reset_sel;
        t_start[T_CLMP] = phase_pulse;
        t_start[T_HOLD] = hold_evt;
        t_dur[T_OFF]  = RLT_TW'(s_reg.regs[IX_OSR][F_OSR_OFF_L +: F_OSR_OFF_W])
                      * RLT_TW'(RLT_FINE_NS);
        t_dur[T_GAP]  = RLT_TW'(s_reg.regs[IX_OSR][F_OSR_GAP_L +: F_OSR_GAP_W])
                      * RLT_TW'(RLT_COARSE_NS);
        t_dur[T_BLNK] = RLT_TW'(s_reg.regs[IX_BLNK][F_BLNK_L +: F_BLNK_W])
                      * RLT_TW'(RLT_FINE_NS);
        t_dur[T_SRST] = RLT_TW'(s_reg.regs[IX_BLNK][F_SRST_L +: F_SRST_W])
                      * RLT_TW'(RLT_FINE_NS);
        t_dur[T_CLMP] = RLT_TW'(s_reg.cfg.clamp_time) * RLT_TW'(RLT_FINE_NS);
        t_dur[T_HOLD] = RLT_TW'(32'(s_reg.regs[IX_HOLD][F_HOLD_T_L +: F_HOLD_T_W])
                      * HOLD_UNIT_NS);
    end

    // ==========================================================================
    // next-state logic
    // ==========================================================================
    always_comb begin
        s_next        = s_reg;
        s_next.rd_ack = 1'b0;
        // host write: only writable bits are stored
        if (cmd.wr) begin
            for (int i = 0; i < NREG; i++) begin
                if (cmd.code == RLT_OFS[i]) begin
                    s_next.regs[i] = cmd.data & RLT_MASK[i];
                end
            end
        end
        // host read: unmapped codes answer zero
        if (cmd.rd) begin
            s_next.rd_ack  = 1'b1;
            s_next.rd_data = '0;
            for (int i = 0; i < NREG; i++) begin
                if (cmd.code == RLT_OFS[i]) begin
                    s_next.rd_data = s_reg.regs[i] & RLT_MASK[i];
                end
            end
        end
        // shedding exit request while any enabled condition is present
        s_next.shed_exit = shedding_active & (
            (s_reg.regs[IX_SHED][B_EXIT_LOW]  & ev.fb_low)
          | (s_reg.regs[IX_SHED][B_EXIT_FREQ] & ev.freq_limit)
          | (s_reg.regs[IX_SHED][B_EXIT_OC]   & ev.oc_phase1));
        // balance loop held by an event or its minimum hold time
        s_next.cb_hold    = hold_evt | t_busy[T_HOLD];
        s_next.phase_prev = phase_mode;
        s_next.dvt_prev   = dvt_active;
        // per phase-count slope and trim selection
        case (phase_mode)
            RLT_PH_3P: begin
                s_next.cfg.clamp_time = s_reg.regs[IX_CL3][F_CLAMP_L +: F_CLAMP_W];
                s_next.cfg.slope_cap  = s_reg.regs[IX_SR3][F_CAP_L +: F_CAP_W];
                s_next.cfg.slope_cur  = s_reg.regs[IX_SR3][F_CUR_L +: F_CUR_W];
                s_next.cfg.trim       = s_reg.regs[IX_TRM2][F_TRM3P_L +: F_TRM_W];
            end
            RLT_PH_2P: begin
                s_next.cfg.clamp_time = s_reg.regs[IX_CL2][F_CLAMP_L +: F_CLAMP_W];
                s_next.cfg.slope_cap  = s_reg.regs[IX_SR2][F_CAP_L +: F_CAP_W];
                s_next.cfg.slope_cur  = s_reg.regs[IX_SR2][F_CUR_L +: F_CUR_W];
                s_next.cfg.trim       = s_reg.regs[IX_TRM1][F_TRM2P_L +: F_TRM_W];
            end
            RLT_PH_1P: begin
                s_next.cfg.clamp_time = s_reg.regs[IX_CL1][F_CLAMP_L +: F_CLAMP_W];
                s_next.cfg.slope_cap  =
                    4'(s_reg.regs[IX_SR1][F_CAP_L +: F_CAP1_W]);
                s_next.cfg.slope_cur  = s_reg.regs[IX_SR1][F_CUR_L +: F_CUR_W];
                s_next.cfg.trim       = s_reg.regs[IX_TRM1][F_TRM1P_L +: F_TRM_W];
            end
            RLT_PH_DCM: begin
                s_next.cfg.clamp_time = s_reg.regs[IX_CLD][F_CLAMP_L +: F_CLAMP_W];
                s_next.cfg.slope_cap  = '0;
                s_next.cfg.slope_cur  = s_reg.regs[IX_SRD][F_CUR_L +: F_CUR_W];
                s_next.cfg.trim       = s_reg.regs[IX_TRM1][F_TRMD_L +: F_TRM_W];
            end
            default: begin
                s_next.cfg.clamp_time = '0;
                s_next.cfg.slope_cap  = '0;
                s_next.cfg.slope_cur  = '0;
                s_next.cfg.trim       = '0;
            end
        endcase
        // loop gains and report format
        s_next.cfg.report_format = s_reg.regs[IX_GAIN][B_FMT];
        s_next.cfg.dc_gain       = s_reg.regs[IX_GAIN][F_DCG_L +: F_DCG_W];
        s_next.cfg.cb_gain       = s_reg.regs[IX_GAIN][F_CBG_L +: F_CBG_W];
    end

    // ==========================================================================
    // state register
    // ==========================================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg            <= '0;
            s_reg.regs       <= {NREG{RLT_RST}};
            s_reg.phase_prev <= RLT_PH_DCM;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign rd_data         = s_reg.rd_data;
    assign rd_ack          = s_reg.rd_ack;
    assign shed_exit       = s_reg.shed_exit;
    assign cb_hold         = s_reg.cb_hold;
    assign cfg             = s_reg.cfg;
    assign osr_pwm_off     = t_busy[T_OFF];
    assign osr_blocked     = t_busy[T_GAP];
    assign pwm_blanking    = t_busy[T_BLNK];
    assign slope_resetting = t_busy[T_SRST];
    assign slope_clamping  = t_busy[T_CLMP];

    // ==========================================================================
    // assertions
    // ==========================================================================
    default clocking cb_main @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_reserved_zero: assert property (cmd.rd && cmd.code == RLT_OFS[IX_SHED]
        |=> rd_ack && rd_data[15:3] == 13'h0000) else $error("reserved bits not zero");
    chk_exit_low_win: assert property (shedding_active && ev.fb_low
        && s_reg.regs[IX_SHED][B_EXIT_LOW] |=> shed_exit) else $error("no exit on low window");
    chk_exit_freq_lim: assert property (shedding_active && ev.freq_limit
        && s_reg.regs[IX_SHED][B_EXIT_FREQ] |=> shed_exit) else $error("no exit on freq limit");
    chk_exit_overcur: assert property ($past(shedding_active) && !shed_exit
        |-> !($past(ev.oc_phase1) && $past(s_reg.regs[IX_SHED][B_EXIT_OC])))
        else $error("no exit on overcurrent");
    chk_osr_off_len: assert property (osr_go && s_reg.regs[IX_OSR][12:7] == 6'h08
        ##1 !osr_go[*2] |-> osr_pwm_off && $past(osr_pwm_off) ##1 !osr_pwm_off)
        else $error("off-time length wrong");
    chk_osr_gap_block: assert property (osr_blocked |-> !$rose(osr_pwm_off)
        or $past(!osr_blocked)) else $error("overshoot event inside gap");
    chk_blank_len: assert property (phase_pulse && s_reg.regs[IX_BLNK][5:0] == 6'h04
        ##1 !phase_pulse |-> pwm_blanking ##1 !pwm_blanking) else $error("blanking length wrong");
    chk_sreset_gate: assert property (phase_pulse && slope_reset_sel && !slope_resetting
        |=> !slope_resetting) else $error("slope reset ran while deselected");
    chk_fmt_write: assert property (cmd.wr && cmd.code == RLT_OFS[IX_GAIN]
        |=> ##1 cfg.report_format == $past(cmd.data[10], 2)) else $error("format not applied");
    chk_gain_write: assert property (cmd.wr && cmd.code == RLT_OFS[IX_GAIN]
        |=> ##1 cfg.dc_gain == $past(cmd.data[9:4], 2) && cfg.cb_gain == $past(cmd.data[3:0], 2))
        else $error("gains not applied");
    chk_hold_trans: assert property (s_reg.regs[IX_HOLD][B_HOLD_TRN] && ev.fb_high
        |=> cb_hold) else $error("no hold on transient");
    chk_hold_phase: assert property (s_reg.regs[IX_HOLD][B_HOLD_PS]
        && phase_mode != s_reg.phase_prev && s_reg.regs[IX_HOLD][3:0] != 4'h0
        |=> cb_hold [*2]) else $error("no hold on phase change");

    // reserved write bits, read answer and write locality
    chk_reserved_drop: assert property (cmd.wr && cmd.code == RLT_OFS[IX_TRM1]
        |=> s_reg.regs[IX_TRM1][15] == 1'b0)
        else $error("reserved bit stored");
    chk_read_ack: assert property (cmd.rd
        |=> rd_ack)
        else $error("read not answered");
    chk_write_local: assert property (cmd.wr && cmd.code != RLT_OFS[IX_GAIN]
        |=> $stable(s_reg.regs[IX_GAIN]))
        else $error("write touched another register");

    // shedding exit only while shedding is in force
    chk_exit_idle: assert property (!shedding_active
        |=> !shed_exit)
        else $error("exit request outside shedding");

    // zero-length timers never start
    chk_blank_zero: assert property (phase_pulse && s_reg.regs[IX_BLNK][5:0] == 6'h00
        |=> !pwm_blanking)
        else $error("blanking ran with zero time");
    chk_clamp_zero: assert property (phase_pulse && cfg.clamp_time == 10'h000
        |=> !slope_clamping)
        else $error("clamp ran with zero time");

    // per phase-count capacitor and trim selection
    chk_cap_dcm: assert property (phase_mode == RLT_PH_DCM
        |=> cfg.slope_cap == 4'h0)
        else $error("capacitor code in discontinuous mode");
    chk_cap_single: assert property (phase_mode == RLT_PH_1P
        |=> cfg.slope_cap[3:1] == 3'b000)
        else $error("wide capacitor code in single phase");
    chk_trim_three: assert property (phase_mode == RLT_PH_3P
        |=> cfg.trim == $past(s_reg.regs[IX_TRM2][4:0]))
        else $error("wrong three-phase trim");

    // balance hold on period, voltage transition and minimum time
    chk_hold_period: assert property (s_reg.regs[IX_HOLD][B_HOLD_PRD] && period_dev_met
        |=> cb_hold)
        else $error("no hold on period condition");
    chk_hold_dvt: assert property (s_reg.regs[IX_HOLD][B_HOLD_DVT] && $rose(dvt_active)
        |=> cb_hold)
        else $error("no hold on voltage transition");
    chk_hold_min: assert property (hold_evt && s_reg.regs[IX_HOLD][3:0] != 4'h0
        |=> cb_hold [*2])
        else $error("hold shorter than minimum");

    cov_shed_exit: cover property ($rose(shed_exit));
    cov_osr_action: cover property ($rose(osr_pwm_off) ##[1:20] osr_trigger && osr_blocked);
    cov_hold_end: cover property ($fell(cb_hold));
    cov_phase_3p: cover property (phase_mode == RLT_PH_3P && slope_clamping);
    cov_hold_period: cover property (period_dev_met && cb_hold);
endmodule // rlt_loop_tuning

// ### rlt_host_model.sv
/* rlt_host_model: page-1 host that issues register writes and reads.
   assumes commands are taken on a rising edge and rd_ack follows one cycle later. */
`timescale 1ns/1ps
module rlt_host_model
    import rlt_pkg::*;
(
    input  wire logic        core_clk,
    output rlt_cmd_s         cmd,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_ack
);
    // ==========================================================================
    // bus cycles: drive after an edge, hold through the taking edge
    // ==========================================================================
    initial cmd = '0;
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(posedge core_clk);
        #1 cmd = '{1'b1, 1'b0, c, v};
        @(posedge core_clk);
        #1 cmd = '{1'b0, 1'b0, c, ~v};  // released data never shows the old word
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(posedge core_clk);
        #1 cmd = '{1'b0, 1'b1, c, 16'h0000};
        @(posedge core_clk);
        #1 v = (rd_ack === 1'b1) ? rd_data : 16'hxxxx;  // missing answer reads unknown
        cmd = '0;
    endtask
endmodule  // rlt_host_model

// ### tb_top.sv
/* tb_top: self-checking bench for rlt_loop_tuning with random register data.
   assumes the host model owns the command port; hold unit shortened to 100 ns. */
`timescale 1ns/1ps
module tb_top;
    import rlt_pkg::*;
    logic        core_clk = 0, nrst = 0, shed = 0, ppul = 0, ssel = 0, overshoot_reduction = 0, pdm = 0, dvt = 0;
    logic        rd_ack, sx, cbh, blk, srs, off, obk, clp;
    logic [15:0] rd_data, d, seed = 16'h004d;
    logic [15:0] sh [NREG];
    rlt_evt_s    ev = '0;
    rlt_phase_e  ph = RLT_PH_DCM;
    rlt_cmd_s    cmd;
    rlt_cfg_s    cfg;
    int          n_mismatch = 0, checks = 0;
    localparam int CL_IX [4] = '{IX_CLD, IX_CL1, IX_CL2, IX_CL3};
    localparam int SR_IX [4] = '{IX_SRD, IX_SR1, IX_SR2, IX_SR3};
    // ==========================================================================
    // clock, design and host
    // ==========================================================================
    always #10 core_clk = ~core_clk;
    rlt_loop_tuning #(.HOLD_UNIT_NS(100)) dut (.core_clk(core_clk), .nrst(nrst), .cmd(cmd),
        .rd_data(rd_data), .rd_ack(rd_ack), .evt_pins(ev), .phase_mode(ph),
        .shedding_active(shed), .osr_trigger(overshoot_reduction), .phase_pulse(ppul),
        .slope_reset_sel(ssel), .period_dev_met(pdm), .dvt_active(dvt), .shed_exit(sx),
        .cb_hold(cbh), .osr_pwm_off(off), .osr_blocked(obk), .pwm_blanking(blk),
        .slope_resetting(srs), .slope_clamping(clp), .cfg(cfg));
    rlt_host_model host (.core_clk(core_clk), .cmd(cmd), .rd_data(rd_data), .rd_ack(rd_ack));
    // ==========================================================================
    // helpers: random words, expected config, compare, wait, verdict
    // ==========================================================================
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic rlt_cfg_s exp_cfg(input int p);
        rlt_cfg_s    c;
        logic [19:0] t;
        t = {sh[IX_TRM2][4:0], sh[IX_TRM1][14:0]};
        c.clamp_time    = sh[CL_IX[p]][9:0];
        c.slope_cur     = sh[SR_IX[p]][5:0];
        c.slope_cap     = (p >= 2) ? sh[SR_IX[p]][9:6] : {3'b000, sh[SR_IX[p]][6]};
        c.trim          = t[p*5 +: 5];
        c.report_format = sh[IX_GAIN][10];
        c.dc_gain       = sh[IX_GAIN][9:4];
        c.cb_gain       = sh[IX_GAIN][3:0];
        return c;
    endfunction
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: far beyond the roughly 570 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end
    // ==========================================================================
    // main sequence
    // ==========================================================================
    initial begin
        cyc(5);
        nrst = 1;
        for (int i = 0; i < NREG; i++) begin
            host.rd(RLT_OFS[i], d);
            chk("reset value", 16'h0000, d);
            seed = lfsr(seed);
            sh[i] = seed & RLT_MASK[i];
            host.wr(RLT_OFS[i], seed);
            host.rd(RLT_OFS[i], d);
            chk("readback", sh[i], d);
        end
        host.rd(8'h45, d);
        chk("unmapped read", 16'h0000, d);
        $display("register test done");
        for (int p = 0; p < 4; p++) begin
            ph = rlt_phase_e'(p);
            cyc(3);
            chk("cfg fields", exp_cfg(p), cfg);
        end
        $display("phase select test done");
        shed = 1;
        for (int b = 0; b < 3; b++) begin
            host.wr(8'hcc, 16'(1 << b));
            ev = rlt_evt_s'(4'(1 << b));
            cyc(6);
            chk("shed exit on", 1'b1, sx);
            host.wr(8'hcc, 16'h0000);
            cyc(3);
            chk("shed exit off", 1'b0, sx);
            ev = '0;
        end
        $display("shedding exit test done");
        host.wr(8'hce, 16'h0084);
        cyc(2);
        for (int s = 0; s < 2; s++) begin
            ssel = s[0];
            ppul = 1;
            cyc(1);
            ppul = 0;
            chk("blanking", 1'b1, blk);
            chk("slope reset", s == 0, srs);
            chk("clamp", sh[IX_CL3][9:0] != 10'h000, clp);
            cyc(1);
            chk("blanking end", 1'b0, blk);
        end
        $display("blanking test done");
        host.wr(8'hcd, 16'h040a);
        overshoot_reduction = 1;
        cyc(1);
        overshoot_reduction = 0;
        chk("osr start", 2'b11, {off, obk});
        cyc(2);
        overshoot_reduction = 1;
        cyc(1);
        overshoot_reduction = 0;
        chk("osr refused", 2'b01, {off, obk});
        cyc(3);
        chk("osr gap end", 1'b0, obk);
        $display("overshoot test done");
        for (int k = 0; k < 4; k++) begin
            host.wr(8'he3, 16'h0001 | (16'h0080 >> k));
            cyc(80);
            if (k == 0) ev.fb_high = 1'b1;
            else if (k == 1) pdm = 1'b1;
            else if (k == 2) ph = RLT_PH_1P;
            else dvt = 1'b1;
            cyc(5);
            chk("balance hold", 1'b1, cbh);
            ev = '0;
            pdm = 1'b0;
            dvt = 1'b0;
            cyc(14);
            chk("balance release", 1'b0, cbh);
        end
        $display("balance hold test done");
        give_verdict();
    end
endmodule  // tb_top
